// ### logic/art_timer.sv
// auto-reload capture timer with ahb-lite register slave
// Functional notes
// - two count bytes; split selects 16/8-bit
// - clocks: core, core/12, rtc/8, comparator
// - 16-bit rollover reloads and sets high flag
// - 16-bit overflow interrupts when timer enabled
// - low wrap interrupts when low enable too
// - split: each byte reloads from own byte
// - split: run gates high; low always runs
// - per-byte core_clock bit, else external select
// - split: each byte wrap sets its flag
// - split: high, or either with low enable
// - flags cleared only by software writes
// - capture enable bit starts capture mode
// - capture on comparator rise or rtc/8
// - capture copies count, sets high flag
// - low wrap always sets low flag
//
// Our own choices: the placing of the registers and the AHB-Lite slave port.
module art_timer
  import art_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        comparator_in,
  input  wire logic        rtc_clk_in,
  output logic             timer_irq
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] count_low_byte;
  logic [7:0] count_high_byte;
  logic [7:0] reload_low_byte;
  logic [7:0] reload_high_byte;
  logic       high_overflow_flag;
  logic       low_overflow_flag;
  logic       low_byte_irq_enable;
  logic       capture_enable;
  logic       split_select;
  logic       run_control;
  logic [1:0] ext_clock_select;
  logic       high_byte_core_clock_select;
  logic       low_byte_core_clock_select;
  logic       timer_interrupt_enable;

  logic [7:0] addr_q;
  logic       wr_pend;
  logic       cmp_rise;
  logic       rtc_rise;
  logic       tick_div12;
  logic       tick_rtc8;
  logic       low_tick;
  logic       high_tick;
  logic       step_low;
  logic       step_high;
  logic       low_wrap;
  logic       high_wrap;
  logic       cap_evt;
  logic [15:0] count_word;
  logic [15:0] reload_word;
  logic [31:0] read_value;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic wr_hit(input logic pend, input logic [7:0] a,
                                  input logic [7:0] off);
    return pend && (a == off);
  endfunction

  // clock-source decode shared by both bytes; reserved code gives no ticks
  function automatic logic src_tick(input logic sys_sel, input logic [1:0] xclk,
                                    input logic d12, input logic r8,
                                    input logic cmp);
    logic t;
    t = 1'b0;
    if (sys_sel) begin
      t = 1'b1;
    end else begin
      case (xclk)
        ART_XCLK_DIV12: t = d12;
        ART_XCLK_RTC8:  t = r8;
        ART_XCLK_CMP:   t = cmp;
        default:        t = 1'b0;
      endcase
    end
    return t;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // clock sources
  art_sync u_sync_cmp (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in (comparator_in),
    .level    (),
    .rise     (cmp_rise)
  );

  art_sync u_sync_rtc (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in (rtc_clk_in),
    .level    (),
    .rise     (rtc_rise)
  );

  art_prescale #(.DIV(ART_SYS_DIV)) u_div12 (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .event_in (1'b1),
    .tick     (tick_div12)
  );

  art_prescale #(.DIV(ART_RTC_DIV)) u_rtc8 (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .event_in (rtc_rise),
    .tick     (tick_rtc8)
  );

  // the divided tick goes in as an argument so the assignment follows its changes
  assign low_tick  = src_tick(low_byte_core_clock_select, ext_clock_select,
                              tick_div12, tick_rtc8, cmp_rise);
  assign high_tick = src_tick(high_byte_core_clock_select, ext_clock_select,
                              tick_div12, tick_rtc8, cmp_rise);

  ////////////////////////////////////////////////////////////////////////////
  // count enables and wrap detection
  assign count_word  = {count_high_byte, count_low_byte};
  assign reload_word = {reload_high_byte, reload_low_byte};
  assign step_low    = low_tick && (split_select || run_control);
  assign step_high   = split_select ? (run_control && high_tick)
                                    : (step_low && count_low_byte == ART_BYTE_MAX);
  assign low_wrap    = step_low && (count_low_byte == ART_BYTE_MAX);
  assign high_wrap   = step_high && (count_high_byte == ART_BYTE_MAX);
  // upper select bit picks the capture source
  assign cap_evt     = capture_enable &&
                       (ext_clock_select[ART_BIT_XCLK_MSB] ? cmp_rise : tick_rtc8);

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: zero wait states, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q  <= ART_BYTE_ZERO;
      wr_pend <= 1'b0;
    end else if (hready) begin
      addr_q  <= haddr[7:0];
      wr_pend <= hsel && |(htrans & ART_HTRANS_NONSEQ_BIT) && hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_comb begin
    read_value = '0;
    case (haddr[7:0])
      ART_OFF_COUNT_LOW:   read_value[7:0] = count_low_byte;
      ART_OFF_COUNT_HIGH:  read_value[7:0] = count_high_byte;
      ART_OFF_RELOAD_LOW:  read_value[7:0] = reload_low_byte;
      ART_OFF_RELOAD_HIGH: read_value[7:0] = reload_high_byte;
      ART_OFF_CONTROL:     read_value[7:0] = {high_overflow_flag, low_overflow_flag,
                                              low_byte_irq_enable, capture_enable,
                                              split_select, run_control,
                                              ext_clock_select};
      ART_OFF_CLOCK_CTRL: begin
        read_value[ART_BIT_LOW_CORE_CLOCK]  = low_byte_core_clock_select;
        read_value[ART_BIT_HIGH_CORE_CLOCK] = high_byte_core_clock_select;
      end
      ART_OFF_IRQ_ENABLE:  read_value[ART_BIT_TIMER_IE] = timer_interrupt_enable;
      default:             read_value = '0;
    endcase
  end

  // read data sampled at the address phase; unmapped reads return zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (hready && hsel && |(htrans & ART_HTRANS_NONSEQ_BIT) && !hwrite) begin
      hrdata <= read_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // count bytes; a software write wins over counting
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_low_byte <= ART_BYTE_RESET;
    end else if (wr_hit(wr_pend, addr_q, ART_OFF_COUNT_LOW)) begin
      count_low_byte <= hwdata[7:0];
    end else if (low_wrap) begin
      if (split_select || count_high_byte == ART_BYTE_MAX) begin
        count_low_byte <= reload_low_byte;
      end else begin
        count_low_byte <= ART_BYTE_ZERO;
      end
    end else if (step_low) begin
      count_low_byte <= 8'(count_low_byte + 1'b1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_high_byte <= ART_BYTE_RESET;
    end else if (wr_hit(wr_pend, addr_q, ART_OFF_COUNT_HIGH)) begin
      count_high_byte <= hwdata[7:0];
    end else if (high_wrap) begin
      count_high_byte <= reload_high_byte;
    end else if (step_high) begin
      count_high_byte <= 8'(count_high_byte + 1'b1);
    end
  end

  // reload bytes; a capture takes the live count over a software write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reload_low_byte  <= ART_BYTE_RESET;
      reload_high_byte <= ART_BYTE_RESET;
    end else if (cap_evt) begin
      reload_low_byte  <= count_low_byte;
      reload_high_byte <= count_high_byte;
    end else begin
      if (wr_hit(wr_pend, addr_q, ART_OFF_RELOAD_LOW)) begin
        reload_low_byte <= hwdata[7:0];
      end
      if (wr_hit(wr_pend, addr_q, ART_OFF_RELOAD_HIGH)) begin
        reload_high_byte <= hwdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register; hardware set wins over a software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      high_overflow_flag  <= 1'b0;
      low_overflow_flag   <= 1'b0;
      low_byte_irq_enable <= 1'b0;
      capture_enable      <= 1'b0;
      split_select        <= 1'b0;
      run_control         <= 1'b0;
      ext_clock_select    <= ART_XCLK_DIV12;
    end else begin
      if (wr_hit(wr_pend, addr_q, ART_OFF_CONTROL)) begin
        high_overflow_flag  <= hwdata[ART_BIT_HIGH_FLAG] | high_wrap | cap_evt;
        low_overflow_flag   <= hwdata[ART_BIT_LOW_FLAG] | low_wrap;
        low_byte_irq_enable <= hwdata[ART_BIT_LOW_IRQ_EN];
        capture_enable      <= hwdata[ART_BIT_CAPTURE_EN];
        split_select        <= hwdata[ART_BIT_SPLIT];
        run_control         <= hwdata[ART_BIT_RUN];
        ext_clock_select    <= hwdata[ART_BIT_XCLK_MSB:ART_BIT_XCLK_LSB];
      end else begin
        high_overflow_flag <= high_overflow_flag | high_wrap | cap_evt;
        low_overflow_flag  <= low_overflow_flag | low_wrap;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_byte_core_clock_select  <= 1'b0;
      high_byte_core_clock_select <= 1'b0;
      timer_interrupt_enable  <= 1'b0;
    end else begin
      if (wr_hit(wr_pend, addr_q, ART_OFF_CLOCK_CTRL)) begin
        low_byte_core_clock_select  <= hwdata[ART_BIT_LOW_CORE_CLOCK];
        high_byte_core_clock_select <= hwdata[ART_BIT_HIGH_CORE_CLOCK];
      end
      if (wr_hit(wr_pend, addr_q, ART_OFF_IRQ_ENABLE)) begin
        timer_interrupt_enable <= hwdata[ART_BIT_TIMER_IE];
      end
    end
  end

  // level request, held until software clears the flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= timer_interrupt_enable &&
                   (high_overflow_flag || (low_byte_irq_enable && low_overflow_flag));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic wr_count_any;
  logic wr_ctrl;
  assign wr_count_any = wr_hit(wr_pend, addr_q, ART_OFF_COUNT_LOW) ||
                        wr_hit(wr_pend, addr_q, ART_OFF_COUNT_HIGH);
  assign wr_ctrl      = wr_hit(wr_pend, addr_q, ART_OFF_CONTROL);

  ovf16_reload_a: assert property (
    (!split_select && step_low && count_word == ART_WORD_MAX && !wr_count_any)
      |=> (count_word == $past(reload_word)) && high_overflow_flag)
    else $error("16-bit overflow did not reload and flag");

  low_wrap_flag_a: assert property (low_wrap |=> low_overflow_flag)
    else $error("low wrap did not set low flag");

  split_reload_a: assert property (
    (split_select && step_low && count_low_byte == ART_BYTE_MAX && !wr_count_any)
      |=> count_low_byte == $past(reload_low_byte))
    else $error("split low byte did not reload from its own byte");

  split_high_hold_a: assert property (
    (split_select && !run_control && !wr_count_any) |=> $stable(count_high_byte))
    else $error("high byte moved while stopped in split mode");

  split_low_runs_a: assert property (
    (split_select && !run_control && low_tick && !wr_count_any
      && count_low_byte != ART_BYTE_MAX)
      |=> count_low_byte == 8'($past(count_low_byte) + 1'b1))
    else $error("split low byte did not count with run off");

  flag_sticky_a: assert property (
    (high_overflow_flag && !wr_ctrl) |=> high_overflow_flag)
    else $error("high flag cleared without a write");

  low_sticky_a: assert property ((low_overflow_flag && !wr_ctrl) |=> low_overflow_flag)
    else $error("low flag cleared without a write");

  capture_copy_a: assert property (
    cap_evt |=> (reload_word == $past(count_word)) && high_overflow_flag)
    else $error("capture did not copy count and flag");

  irq_path_a: assert property (
    (timer_interrupt_enable && high_overflow_flag && !wr_ctrl)
      |=> ##1 timer_irq || !timer_interrupt_enable)
    else $error("interrupt not raised for high flag");

  irq_low_a: assert property (
    (timer_interrupt_enable && low_byte_irq_enable && low_overflow_flag) |=> timer_irq)
    else $error("interrupt not raised for low flag");

  div12_gap_a: assert property (tick_div12 |=> !tick_div12 [*8])
    else $error("core clock divider ticked too soon");

  ovf16_c:  cover property (!split_select && high_wrap);
  split_c:  cover property (split_select && low_wrap ##[1:300] high_wrap);
  capt_c:   cover property (cap_evt ##[1:1000] cap_evt);
endmodule // art_timer

// ### logic/art_pkg.sv
// package: register map, field positions and constants of the auto-reload capture timer
package art_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] ART_OFF_COUNT_LOW   = 8'h00;
  localparam logic [7:0] ART_OFF_COUNT_HIGH  = 8'h04;
  localparam logic [7:0] ART_OFF_RELOAD_LOW  = 8'h08;
  localparam logic [7:0] ART_OFF_RELOAD_HIGH = 8'h0c;
  localparam logic [7:0] ART_OFF_CONTROL     = 8'h10;
  localparam logic [7:0] ART_OFF_CLOCK_CTRL  = 8'h14;
  localparam logic [7:0] ART_OFF_IRQ_ENABLE  = 8'h18;

  // timer_control_reg fields
  localparam int ART_BIT_HIGH_FLAG  = 7;
  localparam int ART_BIT_LOW_FLAG   = 6;
  localparam int ART_BIT_LOW_IRQ_EN = 5;
  localparam int ART_BIT_CAPTURE_EN = 4;
  localparam int ART_BIT_SPLIT      = 3;
  localparam int ART_BIT_RUN        = 2;
  localparam int ART_BIT_XCLK_MSB   = 1;
  localparam int ART_BIT_XCLK_LSB   = 0;

  // clock_control_reg fields
  localparam int ART_BIT_LOW_CORE_CLOCK  = 0;
  localparam int ART_BIT_HIGH_CORE_CLOCK = 1;

  // irq enable register field
  localparam int ART_BIT_TIMER_IE = 0;

  // external clock select encodings
  localparam logic [1:0] ART_XCLK_DIV12 = 2'h0;
  localparam logic [1:0] ART_XCLK_RTC8  = 2'h1;
  localparam logic [1:0] ART_XCLK_CMP   = 2'h3;

  // prescaler ratios
  localparam int unsigned ART_SYS_DIV = 12;
  localparam int unsigned ART_RTC_DIV = 8;

  localparam logic [7:0]  ART_BYTE_MAX   = 8'hff;
  localparam logic [7:0]  ART_BYTE_ZERO  = 8'h00;
  localparam logic [7:0]  ART_BYTE_RESET = 8'h00;
  localparam logic [15:0] ART_WORD_MAX   = 16'hffff;

  localparam logic [1:0] ART_HTRANS_NONSEQ_BIT = 2'h2;
endpackage

// ### logic/art_sync.sv
// two-flop synchroniser with rising-edge pulse for an asynchronous input
module art_sync (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic async_in,
  output logic      level,
  output logic      rise
);
  logic meta;
  logic prev;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta  <= 1'b0;
      level <= 1'b0;
      prev  <= 1'b0;
    end else begin
      meta  <= async_in;
      level <= meta;
      prev  <= level;
    end
  end

  // edge taken from the second and third flops only
  assign rise = level & ~prev;
endmodule // art_sync

// ### logic/art_prescale.sv
// event divider: one tick pulse for every div events
module art_prescale #(
  parameter int unsigned DIV = 12
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic event_in,
  output logic      tick
);
  localparam int W = $clog2(DIV);
  localparam logic [W-1:0] LAST = W'(DIV - 1);
  logic [W-1:0] cnt;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= '0;
    end else if (event_in) begin
      cnt <= (cnt == LAST) ? '0 : W'(cnt + 1'b1);
    end
  end

  assign tick = event_in && (cnt == LAST);
endmodule // art_prescale

// ### test/auto_reload_capture_timer_test.sv
// self-checking testbench for the auto-reload capture timer
module auto_reload_capture_timer_test import art_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;

  logic        hclk;
  logic        hresetn;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        comparator_in;
  logic        rtc_clk_in;
  logic        timer_irq;
  logic        rtc_on;
  int          failures = 0;
  int          n_checks = 0;
  int          cycles   = 0;
  int          rtc_div  = 0;

  art_timer uut (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .hsel          (1'b1),
    .haddr         (haddr),
    .htrans        (htrans),
    .hwrite        (hwrite),
    .hsize         (hsize),
    .hwdata        (hwdata),
    .hready        (hreadyout),
    .hrdata        (hrdata),
    .hreadyout     (hreadyout),
    .hresp         (hresp),
    .comparator_in (comparator_in),
    .rtc_clk_in    (rtc_clk_in),
    .timer_irq     (timer_irq)
  );

  ////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // the whole run needs about 1100 cycles
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      failures++;
      wrap_up;
    end
  end

  // slow clock of four core cycles, held still while off
  always @(posedge hclk) begin
    if (rtc_on) begin
      rtc_div <= rtc_div + 1;
      if (rtc_div % 2 == 1) rtc_clk_in <= ~rtc_clk_in;
    end
  end

  ////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    logic ok;
    ok = (got >= lo) && (got <= hi);
    n_checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("Error at %0t: got %h expected %h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic irq_is(input logic e);
    chk({31'h0, timer_irq}, {31'h0, e}, {31'h0, e});
  endtask

  // single transfer; hready is sampled at each edge before moving on
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, lo, hi);
  endtask

  task automatic rd16(output logic [15:0] v);
    logic [31:0] q;
    bus(1'b0, ART_OFF_RELOAD_LOW, 8'h00, q);
    v[7:0] = q[7:0];
    bus(1'b0, ART_OFF_RELOAD_HIGH, 8'h00, q);
    v[15:8] = q[7:0];
  endtask

  task automatic wait_irq(input int n);
    for (int i = 0; i < n && timer_irq !== 1'b1; i++) @(posedge hclk);
    irq_is(1'b1);
  endtask

  task automatic cmp_pulse;
    comparator_in <= 1'b1;
    repeat (3) @(posedge hclk);
    comparator_in <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask

  ////////////////////////////////////////////////////////////
  task automatic t_reset;
    for (int i = 0; i < 8; i++) rdc(8'(i * 4), 32'h0, 32'h0);
    chk({31'h0, hreadyout}, 32'h1, 32'h1);
    chk({31'h0, hresp}, 32'h0, 32'h0);
    irq_is(1'b0);
  endtask

  task automatic t_wide;
    wr(ART_OFF_CLOCK_CTRL, 8'h01);
    wr(ART_OFF_IRQ_ENABLE, 8'h01);
    wr(ART_OFF_RELOAD_LOW, 8'h34);
    wr(ART_OFF_RELOAD_HIGH, 8'h12);
    wr(ART_OFF_COUNT_LOW, 8'hfd);
    wr(ART_OFF_COUNT_HIGH, 8'hff);
    wr(ART_OFF_CONTROL, 8'h04);
    wait_irq(20);
    rdc(ART_OFF_CONTROL, 32'hc4, 32'hc4);
    wr(ART_OFF_CONTROL, 8'hc0);
    repeat (20) @(posedge hclk);
    rdc(ART_OFF_CONTROL, 32'hc0, 32'hc0);
    rdc(ART_OFF_COUNT_HIGH, 32'h12, 32'h12);
    rdc(ART_OFF_COUNT_LOW, 32'h34, 32'h50);
    irq_is(1'b1);
    wr(ART_OFF_CONTROL, 8'h00);
    repeat (3) @(posedge hclk);
    irq_is(1'b0);
  endtask

  task automatic t_low;
    wr(ART_OFF_COUNT_LOW, 8'hfe);
    wr(ART_OFF_COUNT_HIGH, 8'h00);
    wr(ART_OFF_CONTROL, 8'h04);
    repeat (20) @(posedge hclk);
    rdc(ART_OFF_CONTROL, 32'h44, 32'h44);
    wr(ART_OFF_CONTROL, 8'h40);
    rdc(ART_OFF_CONTROL, 32'h40, 32'h40);
    irq_is(1'b0);
    wr(ART_OFF_CONTROL, 8'h60);
    repeat (3) @(posedge hclk);
    irq_is(1'b1);
    wr(ART_OFF_CONTROL, 8'h00);
  endtask

  task automatic t_split;
    wr(ART_OFF_CLOCK_CTRL, 8'h03);
    wr(ART_OFF_RELOAD_LOW, 8'hf0);
    wr(ART_OFF_RELOAD_HIGH, 8'h80);
    wr(ART_OFF_COUNT_LOW, 8'hfe);
    wr(ART_OFF_COUNT_HIGH, 8'hfe);
    wr(ART_OFF_CONTROL, 8'h08);
    repeat (40) @(posedge hclk);
    rdc(ART_OFF_COUNT_HIGH, 32'hfe, 32'hfe);
    rdc(ART_OFF_COUNT_LOW, 32'hf0, 32'hff);
    rdc(ART_OFF_CONTROL, 32'h48, 32'h48);
    irq_is(1'b0);
    wr(ART_OFF_CONTROL, 8'h4c);
    repeat (10) @(posedge hclk);
    rdc(ART_OFF_COUNT_HIGH, 32'h80, 32'h8f);
    rdc(ART_OFF_CONTROL, 32'hcc, 32'hcc);
    irq_is(1'b1);
    wr(ART_OFF_CONTROL, 8'h48);
    repeat (3) @(posedge hclk);
    irq_is(1'b0);
    wr(ART_OFF_CONTROL, 8'h68);
    repeat (3) @(posedge hclk);
    irq_is(1'b1);
    wr(ART_OFF_CONTROL, 8'h00);
  endtask

  // 00 core/12, 01 rtc/8, 10 reserved, 11 comparator; one window each
  task automatic t_sources;
    logic [31:0] lo[4] = '{32'd9, 32'd9, 32'd0, 32'd4};
    logic [31:0] hi[4] = '{32'd11, 32'd11, 32'd0, 32'd4};
    wr(ART_OFF_CLOCK_CTRL, 8'h00);
    for (logic [7:0] s = 0; s < 4; s++) begin
      wr(ART_OFF_COUNT_LOW, 8'h00);
      wr(ART_OFF_COUNT_HIGH, 8'h00);
      wr(ART_OFF_CONTROL, 8'h04 | s);
      if (s == 1) rtc_on <= 1'b1;
      if (s == 3) repeat (4) cmp_pulse;
      repeat ((s == 1) ? 318 : 118) @(posedge hclk);
      wr(ART_OFF_CONTROL, 8'h00);
      rtc_on <= 1'b0;
      rdc(ART_OFF_COUNT_LOW, lo[s[1:0]], hi[s[1:0]]);
    end
  endtask

  task automatic t_capture;
    int          c1;
    logic [15:0] a;
    logic [15:0] b;
    wr(ART_OFF_CLOCK_CTRL, 8'h01);
    wr(ART_OFF_COUNT_LOW, 8'h00);
    wr(ART_OFF_COUNT_HIGH, 8'h00);
    wr(ART_OFF_CONTROL, 8'h17);
    c1 = cycles;
    cmp_pulse;
    rd16(a);
    chk({16'h0, a}, 32'h1, 32'hffff);
    rdc(ART_OFF_CONTROL, 32'h97, 32'h97);
    irq_is(1'b1);
    wr(ART_OFF_CONTROL, 8'h17);
    // second edge exactly 100 core cycles after the first
    while (cycles < c1 + 100) @(posedge hclk);
    cmp_pulse;
    rd16(b);
    chk({16'h0, b - a}, 32'd100, 32'd100);
    wr(ART_OFF_CONTROL, 8'h15);
    rtc_on <= 1'b1;
    repeat (2) @(posedge hclk);
    wait_irq(100);
    rtc_on <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    hresetn       = 1'b0;
    haddr         = 32'h0;
    htrans        = 2'h0;
    hwrite        = 1'b0;
    hsize         = 3'h2;
    hwdata        = 32'h0;
    comparator_in = 1'b0;
    rtc_clk_in    = 1'b0;
    rtc_on        = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_wide;
    t_low;
    t_split;
    t_sources;
    t_capture;
    wrap_up;
  end
endmodule // auto_reload_capture_timer_test
